/* File: hdl/swb_slot_timing.sv */
// bus-side slot timing engine: reset/presence, write and read slots
`timescale 1ns/1ps
// Operation
// (R01) master starts every slot kind; only presence comes from the slave
// (R02) reset pulse drives line low 488 ticks, 61 in overdrive, then releases
// (R03) slave waits 26-60 us after rise, then presence low 104-240 us
// (R04) after reset release wait at most 60 us (6 overdrive) for falling edge
// (R05) sample presence 30 ticks (3 overdrive) after slave response
// (R06) sampled presence level is stored in the presence result flag
// (R07) result reads 0 when slave answered, 1 when none; resets to 1
// (R08) presence seen flag set after presence time; resets 0, cleared by read
// (R09) reset slot ends 500 ticks (50 overdrive) after line release
// (R10) every write slot begins by pulling the idle-high line low
// (R11) write one releases line after 6 ticks, 1 in overdrive
// (R12) write zero holds line low 63 ticks, 8 in overdrive
// (R13) slave samples 15-60 us (2-6 overdrive) after fall, high means one
// (R14) read slot starts with line low at least 1 us, then release
// (R15) slave returning zero holds low up to 60 us, one releases at once
// (R16) read bit sampled 15 us after slot start, 2 us in overdrive
// (R17) read slot total length 73 ticks, 11 in overdrive
// (R18) all durations counted in system-clock-derived ticks of 1 to 1.25 us
// (R19) overdrive select picks overdrive counts for reset, write and read
// (R20) write slot length equals read slot, then at least 1 us recovery
module swb_slot_timing #(
	parameter int unsigned TICK_DIV = swb_pkg::TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic overdrive_select,
	input wire logic cmd_valid,
	input wire swb_pkg::swb_cmd_t cmd,
	output logic cmd_ready,
	output logic done,
	output logic read_bit,
	output logic presence_result_flag,
	output logic presence_seen_flag,
	input wire logic presence_clear,
	input wire logic line_i,
	output logic line_o,
	output logic line_oe
);
	logic tick;
	logic restart;
	logic ln_meta_q;
	logic ln_sync_q;
	logic ln_prev_q;
	logic fall;
	logic seen_set;
	logic [swb_pkg::CNT_W-1:0] cnt_inc;
	logic [swb_pkg::CNT_W-1:0] pcnt_inc;
	logic [swb_pkg::CNT_W-1:0] low_len;
	swb_pkg::swb_state_t state_q;
	swb_pkg::swb_state_t state_d;
	swb_pkg::swb_pres_t pres_q;
	swb_pkg::swb_pres_t pres_d;
	swb_pkg::swb_kind_t kind_q;
	swb_pkg::swb_kind_t kind_d;
	logic [swb_pkg::CNT_W-1:0] cnt_q;
	logic [swb_pkg::CNT_W-1:0] cnt_d;
	logic [swb_pkg::CNT_W-1:0] pcnt_q;
	logic [swb_pkg::CNT_W-1:0] pcnt_d;
	logic bit_q;
	logic bit_d;
	logic od_q;
	logic od_d;
	logic oe_q;
	logic oe_d;
	logic ready_q;
	logic ready_d;
	logic done_q;
	logic done_d;
	logic rbit_q;
	logic rbit_d;
	logic presres_q;
	logic presres_d;
	logic seen_q;
	logic seen_d;
	logic line_o_q;

	// true on the tick that completes n ticks of the phase
	function automatic logic elapsed(input logic tk, input logic [swb_pkg::CNT_W-1:0] cnt,
		input logic [swb_pkg::CNT_W-1:0] n);
		return tk && (cnt == n - 10'h001);
	endfunction

	function automatic logic [swb_pkg::CNT_W-1:0] pick(input logic od,
		input logic [swb_pkg::CNT_W-1:0] nrm, input logic [swb_pkg::CNT_W-1:0] ovr);
		return od ? ovr : nrm; // see (R19)
	endfunction

	swb_tick #(
		.TICK_DIV(TICK_DIV)
	) u_tick (
		.core_clk(core_clk),
		.reset(reset),
		.restart(restart),
		.tick(tick) // see (R18)
	);

	// line input is asynchronous to core_clk
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ln_meta_q <= 1'b1;
			ln_sync_q <= 1'b1;
			ln_prev_q <= 1'b1;
		end else begin
			ln_meta_q <= line_i;
			ln_sync_q <= ln_meta_q;
			ln_prev_q <= ln_sync_q;
		end
	end

	assign fall = ln_prev_q & ~ln_sync_q;
	assign cnt_inc = tick ? cnt_q + 10'h001 : cnt_q;
	assign pcnt_inc = tick ? pcnt_q + 10'h001 : pcnt_q;

	always_comb begin
		state_d = state_q;
		pres_d = pres_q;
		kind_d = kind_q;
		cnt_d = cnt_q;
		pcnt_d = pcnt_q;
		bit_d = bit_q;
		od_d = od_q;
		oe_d = oe_q;
		done_d = 1'b0;
		rbit_d = rbit_q;
		presres_d = presres_q;
		seen_set = 1'b0;
		restart = 1'b0;
		low_len = swb_pkg::READ_LOW_TIME;
		unique case (state_q)
			swb_pkg::ST_IDLE: begin
				oe_d = 1'b0;
				if (cmd_valid && ready_q) begin
					// speed is latched so one slot never mixes both tables
					od_d = overdrive_select; // see (R19)
					kind_d = cmd.kind;
					bit_d = cmd.bit_val;
					restart = 1'b1;
					cnt_d = '0;
					oe_d = 1'b1; // see (R01), (R10), (R14)
					state_d = (cmd.kind == swb_pkg::SWB_KIND_RESET) ?
						swb_pkg::ST_RST_LOW : swb_pkg::ST_SLOT;
				end
			end
			swb_pkg::ST_RST_LOW: begin
				cnt_d = cnt_inc;
				if (elapsed(tick, cnt_q, pick(od_q, swb_pkg::RESET_LOW_TIME_N,
					swb_pkg::RESET_LOW_TIME_O))) begin
					oe_d = 1'b0; // see (R02)
					cnt_d = '0;
					pcnt_d = '0;
					pres_d = swb_pkg::PW_WAIT;
					state_d = swb_pkg::ST_RST_HIGH;
				end
			end
			swb_pkg::ST_RST_HIGH: begin
				cnt_d = cnt_inc;
				pcnt_d = pcnt_inc;
				unique case (pres_q)
					swb_pkg::PW_WAIT: begin
						if (fall) begin
							pcnt_d = '0;
							pres_d = swb_pkg::PW_SAMPLE;
						end else if (elapsed(tick, pcnt_q, pick(od_q,
							swb_pkg::PRESENCE_WAIT_N, swb_pkg::PRESENCE_WAIT_O))) begin
							presres_d = 1'b1; // see (R04), (R07)
							seen_set = 1'b1; // see (R08)
							pres_d = swb_pkg::PW_DONE;
						end
					end
					swb_pkg::PW_SAMPLE: begin
						if (elapsed(tick, pcnt_q, pick(od_q, swb_pkg::PRESENCE_SAMPLE_TIME_N,
							swb_pkg::PRESENCE_SAMPLE_TIME_O))) begin
							presres_d = ln_sync_q; // see (R05), (R06), (R07)
							seen_set = 1'b1; // see (R08)
							pres_d = swb_pkg::PW_DONE;
						end
					end
					swb_pkg::PW_DONE: begin
						pcnt_d = pcnt_q;
					end
				endcase
				if (elapsed(tick, cnt_q, pick(od_q, swb_pkg::RESET_HIGH_TIME_N,
					swb_pkg::RESET_HIGH_TIME_O))) begin
					done_d = 1'b1; // see (R09)
					state_d = swb_pkg::ST_IDLE;
				end
			end
			swb_pkg::ST_SLOT: begin
				cnt_d = cnt_inc;
				if (kind_q == swb_pkg::SWB_KIND_WRITE) begin
					low_len = bit_q ?
						pick(od_q, swb_pkg::ONE_LOW_TIME_N, swb_pkg::ONE_LOW_TIME_O) :
						pick(od_q, swb_pkg::ZERO_LOW_TIME_N, swb_pkg::ZERO_LOW_TIME_O);
				end
				if (elapsed(tick, cnt_q, low_len)) begin
					oe_d = 1'b0; // see (R11), (R12), (R14)
				end
				if (kind_q == swb_pkg::SWB_KIND_READ && elapsed(tick, cnt_q,
					pick(od_q, swb_pkg::READ_VALID_TIME_N, swb_pkg::READ_VALID_TIME_O))) begin
					rbit_d = ln_sync_q; // see (R16)
				end
				if (elapsed(tick, cnt_q, pick(od_q, swb_pkg::SLOT_LENGTH_N,
					swb_pkg::SLOT_LENGTH_O))) begin
					oe_d = 1'b0;
					cnt_d = '0;
					state_d = swb_pkg::ST_RECOVER; // see (R17), (R20)
				end
			end
			swb_pkg::ST_RECOVER: begin
				cnt_d = cnt_inc;
				if (elapsed(tick, cnt_q, swb_pkg::RECOVERY_TIME)) begin
					done_d = 1'b1; // see (R20)
					state_d = swb_pkg::ST_IDLE;
				end
			end
			default: begin
				oe_d = 1'b0;
				state_d = swb_pkg::ST_IDLE;
			end
		endcase
		ready_d = (state_d == swb_pkg::ST_IDLE);
		// a new presence event beats a clear in the same cycle
		seen_d = seen_set | (seen_q & ~presence_clear); // see (R08)
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= swb_pkg::ST_IDLE;
			pres_q <= swb_pkg::PW_DONE;
			kind_q <= swb_pkg::SWB_KIND_RESET;
			cnt_q <= '0;
			pcnt_q <= '0;
			bit_q <= 1'b0;
			od_q <= 1'b0;
			oe_q <= 1'b0;
			ready_q <= 1'b1;
			done_q <= 1'b0;
			rbit_q <= 1'b0;
			presres_q <= swb_pkg::PRESENCE_RESULT_RESET;
			seen_q <= 1'b0;
			line_o_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pres_q <= pres_d;
			kind_q <= kind_d;
			cnt_q <= cnt_d;
			pcnt_q <= pcnt_d;
			bit_q <= bit_d;
			od_q <= od_d;
			oe_q <= oe_d;
			ready_q <= ready_d;
			done_q <= done_d;
			rbit_q <= rbit_d;
			presres_q <= presres_d;
			seen_q <= seen_d;
			// open drain: only ever drives low
			line_o_q <= 1'b0;
		end
	end

	assign cmd_ready = ready_q;
	assign done = done_q;
	assign read_bit = rbit_q;
	assign presence_result_flag = presres_q;
	assign presence_seen_flag = seen_q;
	assign line_o = line_o_q;
	assign line_oe = oe_q;
endmodule // swb_slot_timing

/* File: include/swb_pkg.sv */
// shared constants and types for the single-wire bus slot timing engine
package swb_pkg;

	// system clock and timebase
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned TICK_NS = 1000;
	// least tick period, so round up
	localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int unsigned CNT_W = 10;

	// durations in timebase ticks
	localparam logic [CNT_W-1:0] RESET_LOW_TIME_N = 10'h1E8;
	localparam logic [CNT_W-1:0] RESET_LOW_TIME_O = 10'h03D;
	localparam logic [CNT_W-1:0] RESET_HIGH_TIME_N = 10'h1F4;
	localparam logic [CNT_W-1:0] RESET_HIGH_TIME_O = 10'h032;
	localparam logic [CNT_W-1:0] PRESENCE_SAMPLE_TIME_N = 10'h01E;
	localparam logic [CNT_W-1:0] PRESENCE_SAMPLE_TIME_O = 10'h003;
	localparam logic [CNT_W-1:0] ZERO_LOW_TIME_N = 10'h03F;
	localparam logic [CNT_W-1:0] ZERO_LOW_TIME_O = 10'h008;
	localparam logic [CNT_W-1:0] ONE_LOW_TIME_N = 10'h006;
	localparam logic [CNT_W-1:0] ONE_LOW_TIME_O = 10'h001;
	localparam logic [CNT_W-1:0] SLOT_LENGTH_N = 10'h049;
	localparam logic [CNT_W-1:0] SLOT_LENGTH_O = 10'h00B;

	// durations in microseconds, turned into ticks below
	localparam int unsigned PRESENCE_WAIT_US_N = 60;
	localparam int unsigned PRESENCE_WAIT_US_O = 6;
	localparam int unsigned READ_VALID_TIME_US_N = 15;
	localparam int unsigned READ_VALID_TIME_US_O = 2;
	localparam int unsigned READ_LOW_US = 1;
	localparam int unsigned RECOVERY_US = 1;

	// longest wait rounds down, least times round up
	localparam logic [CNT_W-1:0] PRESENCE_WAIT_N = CNT_W'(PRESENCE_WAIT_US_N * 1000 / TICK_NS);
	localparam logic [CNT_W-1:0] PRESENCE_WAIT_O = CNT_W'(PRESENCE_WAIT_US_O * 1000 / TICK_NS);
	localparam logic [CNT_W-1:0] READ_VALID_TIME_N =
		CNT_W'((READ_VALID_TIME_US_N * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [CNT_W-1:0] READ_VALID_TIME_O =
		CNT_W'((READ_VALID_TIME_US_O * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [CNT_W-1:0] READ_LOW_TIME = CNT_W'((READ_LOW_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [CNT_W-1:0] RECOVERY_TIME = CNT_W'((RECOVERY_US * 1000 + TICK_NS - 1) / TICK_NS);

	localparam logic PRESENCE_RESULT_RESET = 1'b1;

	typedef enum logic [1:0] {
		SWB_KIND_RESET,
		SWB_KIND_WRITE,
		SWB_KIND_READ
	} swb_kind_t;

	typedef struct packed {
		swb_kind_t kind;
		logic bit_val;
	} swb_cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RST_LOW,
		ST_RST_HIGH,
		ST_SLOT,
		ST_RECOVER
	} swb_state_t;

	typedef enum logic [1:0] {
		PW_WAIT,
		PW_SAMPLE,
		PW_DONE
	} swb_pres_t;

endpackage

/* File: hdl/swb_tick.sv */
// timebase divider producing one tick pulse per timebase period
`timescale 1ns/1ps
module swb_tick #(
	parameter int unsigned TICK_DIV = swb_pkg::TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic restart,
	output logic tick
);
	logic [15:0] div_q;
	logic [15:0] div_d;
	logic tick_q;
	logic tick_d;

	always_comb begin
		tick_d = 1'b0;
		div_d = div_q + 16'h0001;
		if (restart) begin
			// realign so slot timing starts at a tick boundary
			div_d = 16'h0000;
		end else if (div_q == 16'(TICK_DIV - 1)) begin
			div_d = 16'h0000;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule // swb_tick

/* File: tb/swb_slot_timing_properties.sv */
// timing checker for the slot timing engine
`timescale 1ns/1ps
module swb_slot_props #(
	parameter int unsigned TICK_DIV = swb_pkg::TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic overdrive_select,
	input wire logic cmd_valid,
	input wire swb_pkg::swb_cmd_t cmd,
	input wire logic cmd_ready,
	input wire logic done,
	input wire logic read_bit,
	input wire logic presence_result_flag,
	input wire logic presence_seen_flag,
	input wire logic presence_clear,
	input wire logic line_i,
	input wire logic line_o,
	input wire logic line_oe
);
	int unsigned low_d, low_q, age_d, age_q;
	swb_pkg::swb_cmd_t cmd_d, cmd_q;
	logic od_d, od_q;
	function automatic int unsigned tk(input logic [9:0] n, input logic [9:0] o);
		return (od_q ? o : n) * TICK_DIV;
	endfunction
	// three cycles of slack each way; a one-tick slip is caught while TICK_DIV > 3
	function automatic logic near(input int unsigned got, input int unsigned want);
		return got + 3 >= want && got <= want + 3;
	endfunction
	always_comb begin
		low_d = line_oe ? low_q + 1 : 0;
		age_d = (cmd_valid && cmd_ready) ? 0 : age_q + 1;
		cmd_d = (cmd_valid && cmd_ready) ? cmd : cmd_q;
		od_d = (cmd_valid && cmd_ready) ? overdrive_select : od_q;
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			low_q <= 0;
			age_q <= 0;
			cmd_q <= '0;
			od_q <= 1'b0;
		end else begin
			low_q <= low_d;
			age_q <= age_d;
			cmd_q <= cmd_d;
			od_q <= od_d;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence take_s;
		cmd_valid && cmd_ready;
	endsequence
	sequence release_s(swb_pkg::swb_kind_t k);
		$fell(line_oe) ##0 (cmd_q.kind == k);
	endsequence
	slot_start_a: assert property (take_s |=> line_oe && !cmd_ready)
		else $error("slot did not open with the line low");
	idle_quiet_a: assert property (cmd_ready |-> !line_oe)
		else $error("line driven while idle");
	write_low_a: assert property (
		release_s(swb_pkg::SWB_KIND_WRITE) |-> near(low_q,
		cmd_q.bit_val ? tk(swb_pkg::ONE_LOW_TIME_N, swb_pkg::ONE_LOW_TIME_O)
		: tk(swb_pkg::ZERO_LOW_TIME_N, swb_pkg::ZERO_LOW_TIME_O)))
		else $error("write low time wrong");
	reset_low_a: assert property (
		release_s(swb_pkg::SWB_KIND_RESET) |-> near(low_q,
		tk(swb_pkg::RESET_LOW_TIME_N, swb_pkg::RESET_LOW_TIME_O)))
		else $error("reset low time wrong");
	read_low_a: assert property (
		release_s(swb_pkg::SWB_KIND_READ) |-> near(low_q,
		swb_pkg::READ_LOW_TIME * TICK_DIV))
		else $error("read low time wrong");
	slot_len_a: assert property (
		done && cmd_q.kind != swb_pkg::SWB_KIND_RESET |-> near(age_q,
		tk(swb_pkg::SLOT_LENGTH_N, swb_pkg::SLOT_LENGTH_O) + TICK_DIV))
		else $error("slot length wrong");
	reset_len_a: assert property (
		done && cmd_q.kind == swb_pkg::SWB_KIND_RESET |-> near(age_q,
		tk(swb_pkg::RESET_LOW_TIME_N, swb_pkg::RESET_LOW_TIME_O)
		+ tk(swb_pkg::RESET_HIGH_TIME_N, swb_pkg::RESET_HIGH_TIME_O)))
		else $error("reset slot length wrong");
	done_pulse_a: assert property (done |-> cmd_ready ##1 !done)
		else $error("done not a single pulse");
	presence_by_a: assert property (
		$rose(presence_seen_flag) |-> cmd_q.kind ==
		swb_pkg::SWB_KIND_RESET && !cmd_ready && age_q <= tk(swb_pkg::RESET_LOW_TIME_N,
		swb_pkg::RESET_LOW_TIME_O) + tk(swb_pkg::PRESENCE_WAIT_N,
		swb_pkg::PRESENCE_WAIT_O) + 2 * TICK_DIV)
		else $error("presence evaluated late or outside reset");
	result_src_a: assert property (
		$changed(presence_result_flag) |->
		cmd_q.kind == swb_pkg::SWB_KIND_RESET && !cmd_ready)
		else $error("presence result moved outside reset");
	readbit_src_a: assert property (
		$changed(read_bit) |->
		cmd_q.kind == swb_pkg::SWB_KIND_READ && !cmd_ready)
		else $error("read bit moved outside read slot");
endmodule // swb_slot_props
bind swb_slot_timing swb_slot_props #(
	.TICK_DIV(TICK_DIV)
) u_props (
	.core_clk(core_clk),
	.reset(reset),
	.overdrive_select(overdrive_select),
	.cmd_valid(cmd_valid),
	.cmd(cmd),
	.cmd_ready(cmd_ready),
	.done(done),
	.read_bit(read_bit),
	.presence_result_flag(presence_result_flag),
	.presence_seen_flag(presence_seen_flag),
	.presence_clear(presence_clear),
	.line_i(line_i),
	.line_o(line_o),
	.line_oe(line_oe)
);

/* File: tb/swb_slave_model.sv */
// behavioural slave on the shared line
`timescale 1ns/1ps
module swb_slave_model #(
	parameter int TK = 32
) (
	input wire logic line,
	input wire logic od,
	input wire logic present,
	input wire logic reply,
	output logic slave_low,
	output logic seen_bit
);
	realtime t0;
	initial begin
		slave_low = 1'b0;
		seen_bit = 1'b0;
		forever begin
			@(negedge line);
			t0 = $realtime;
			// a zero reply also lands inside a reset, where it is harmless
			if (!reply) begin
				slave_low = 1'b1;
				fork
					#((od ? 4 : 25) * TK) slave_low = 1'b0;
				join_none
			end
			#((od ? 3 : 30) * TK) seen_bit = line;
			wait (line === 1'b1);
			if (present && ($realtime - t0) > (od ? 30 : 200) * TK) begin
				#((od ? 3 : 30) * TK) slave_low = 1'b1;
				#((od ? 12 : 120) * TK) slave_low = 1'b0;
			end
		end
	end
endmodule // swb_slave_model

/* File: tb/tb_top.sv */
// self-checking bench for the slot timing engine
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic od = 1'b0;
	logic cmd_valid = 1'b0;
	swb_pkg::swb_cmd_t cmd = '0;
	logic presence_clear = 1'b0;
	logic present = 1'b1;
	logic reply = 1'b1;
	logic cmd_ready, done, read_bit, res_flag, seen_flag, line_o, line_oe, slave_low, seen_bit;
	// pull-up: high unless someone drives low
	wire logic bus_line = !((line_oe && !line_o) || slave_low);
	int err_total = 0;
	int num_checks = 0;
	always #4 core_clk = ~core_clk;
	swb_slot_timing #(.TICK_DIV(4)) DUT (
		.core_clk(core_clk),
		.reset(reset),
		.overdrive_select(od),
		.cmd_valid(cmd_valid),
		.cmd(cmd),
		.cmd_ready(cmd_ready),
		.done(done),
		.read_bit(read_bit),
		.presence_result_flag(res_flag),
		.presence_seen_flag(seen_flag),
		.presence_clear(presence_clear),
		.line_i(bus_line),
		.line_o(line_o),
		.line_oe(line_oe)
	);
	swb_slave_model #(.TK(32)) u_slave (
		.line(bus_line),
		.od(od),
		.present(present),
		.reply(reply),
		.slave_low(slave_low),
		.seen_bit(seen_bit)
	);
	task automatic chk(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic run_cmd(input swb_pkg::swb_kind_t k, input logic b, input logic o);
		int i;
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd <= '{kind: k, bit_val: b};
		od <= o;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		i = 0;
		do begin
			@(posedge core_clk);
			#1;
			i++;
		end while (done !== 1'b1 && i < 5000);
		chk("done", 1'b1, done);
	endtask
	task automatic t_reset_state;
		chk("result after reset", 1'b1, res_flag);
		chk("seen after reset", 1'b0, seen_flag);
		chk("line after reset", 1'b0, line_oe);
		chk("drive level", 1'b0, line_o);
	endtask
	task automatic t_presence(input logic o, input logic p);
		present = p;
		run_cmd(swb_pkg::SWB_KIND_RESET, 1'b0, o);
		chk("presence result", !p, res_flag);
		chk("presence seen", 1'b1, seen_flag);
		@(posedge core_clk);
		presence_clear <= 1'b1;
		@(posedge core_clk);
		presence_clear <= 1'b0;
		#1;
		chk("seen after clear", 1'b0, seen_flag);
		chk("result after clear", !p, res_flag);
	endtask
	task automatic t_write(input logic o, input logic b);
		run_cmd(swb_pkg::SWB_KIND_WRITE, b, o);
		chk("slave bit", b, seen_bit);
	endtask
	task automatic t_read(input logic o, input logic b);
		reply = b;
		run_cmd(swb_pkg::SWB_KIND_READ, 1'b0, o);
		reply = 1'b1;
		chk("read bit", b, read_bit);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		#1;
		t_reset_state();
		for (int o = 0; o < 2; o++) begin
			t_presence(o[0], 1'b1);
			t_presence(o[0], 1'b0);
			for (int b = 0; b < 2; b++) begin
				t_write(o[0], b[0]);
				t_read(o[0], b[0]);
			end
		end
		end_sim();
	end
	// whole run needs about 82 us; give it about five times that
	initial begin
		#400000;
		err_total++;
		end_sim();
	end
endmodule // tb_top
